// File: hdl/recorder_pkg.sv
// Constants and carrier types for the recorder pin and memory-map block.
// Assumes a 100 MHz system clock and a free-running 32.768 kHz timebase pin.
package recorder_pkg;
  localparam int PAGE_BYTES = 32;
  localparam logic [15:0] CTRL_BASE = 16'h0000;
  localparam logic [15:0] CTRL_END = 16'h003f;
  localparam logic [15:0] USER_BASE = 16'h0040;
  localparam logic [15:0] USER_END = 16'h005f;
  localparam logic [15:0] SERIAL_BASE = 16'h0218;
  localparam logic [15:0] SERIAL_END = 16'h021f;
  localparam logic [15:0] ALARM_BASE = 16'h0220;
  localparam logic [15:0] ALARM_END = 16'h027f;
  localparam logic [15:0] THIST_BASE = 16'h0800;
  localparam int THIST_BINS = 63;
  localparam logic [15:0] AHIST_BASE = 16'h0880;
  localparam int AHIST_BINS = 64;
  localparam logic [15:0] LOG_BASE = 16'h1000;
  localparam logic [15:0] LOG_END = 16'h17ff;
  localparam logic [15:0] THIST_END = 16'(THIST_BASE + 2 * THIST_BINS - 1);
  localparam logic [15:0] AHIST_END = 16'(AHIST_BASE + 2 * AHIST_BINS - 1);
  // Offsets inside the control pages
  localparam logic [5:0] SAMPLE_RATE_OFS = 6'h0d;
  localparam logic [5:0] CTRL1_OFS = 6'h0e;
  localparam logic [5:0] DELAY_LO_OFS = 6'h12;
  localparam logic [5:0] DELAY_HI_OFS = 6'h13;
  localparam logic [5:0] STATUS1_OFS = 6'h14;
  localparam int SE_BIT = 4;
  localparam int MIP_BIT = 5;
  localparam logic [2:0] FLAG_MASK = 3'h7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Read-only store layout, byte indices
  localparam int ALARM_IDX = 0;
  localparam int THIST_IDX = 96;
  localparam int AHIST_IDX = 224;
  localparam int LOG_IDX = 352;
  localparam int RO_BYTES = 2400;
  // Button qualification, counted in timebase periods
  localparam int BUTTON_MIN_MS = 500;
  localparam int TIMEBASE_HZ = 32768;
  localparam int BUTTON_LOW_SAMPLES = TIMEBASE_HZ * BUTTON_MIN_MS / 1000;
  localparam int CLK_HZ = 100000000;

  typedef enum {
    REG_CTRL, REG_USER, REG_SERIAL, REG_ALARM, REG_THIST, REG_AHIST, REG_LOG, REG_RESERVED
  } region_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic en;
    logic [11:0] idx;
    logic [7:0] data;
  } store_wr_t;

  typedef struct packed {
    logic [7:0] sample_rate;
    logic [15:0] start_delay;
  } mission_cfg_t;
endpackage

// File: hdl/recorder_pins.sv
// Pin behaviour and address decoding of the data recorder.
// Assumes a register master on clock_in and pins from outside that domain.
`timescale 1ns/100ps

module recorder_pins
  import recorder_pkg::*;
#(
  parameter logic [63:0] SERIAL_NUMBER = 64'h0011223344556677  // Arbitrary value
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire recorder_pkg::bus_req_t bus_in,
  output logic [7:0] rdata_out,
  input wire recorder_pkg::store_wr_t store_wr_in,
  input wire logic [2:0] flag_set_in,
  input wire logic comm_mode_select_in,
  input wire logic vcc_present_in,
  input wire logic start_status_button_n_in,
  input wire logic timebase_in,
  input wire logic tx_data_in,
  output logic tx_out,
  output logic tx_oe_out,
  output logic sync_port_en_out,
  output logic async_port_en_out,
  output logic int_n_out,
  output logic int_n_oe_out,
  output logic in_limits_indicator_out,
  output logic in_limits_indicator_oe_out,
  output logic out_of_limits_indicator_out,
  output logic out_of_limits_indicator_oe_out,
  output logic mission_start_out,
  output recorder_pkg::mission_cfg_t mission_cfg_out
);
  import recorder_pkg::*;

  localparam int SYNC_N = 4;
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(BUTTON_LOW_SAMPLES - 1);

  function automatic region_t decode(input logic [15:0] a);
    if (a <= CTRL_END) begin
      decode = REG_CTRL;
    end else if (a >= USER_BASE && a <= USER_END) begin
      decode = REG_USER;
    end else if (a >= SERIAL_BASE && a <= SERIAL_END) begin
      decode = REG_SERIAL;
    end else if (a >= ALARM_BASE && a <= ALARM_END) begin
      decode = REG_ALARM;
    end else if (a >= THIST_BASE && a <= THIST_END) begin
      decode = REG_THIST;
    end else if (a >= AHIST_BASE && a <= AHIST_END) begin
      decode = REG_AHIST;
    end else if (a >= LOG_BASE && a <= LOG_END) begin
      decode = REG_LOG;
    end else begin
      decode = REG_RESERVED;
    end
  endfunction

  // Index into the read-only store; regions are whole 32-byte pages except the 126-byte THIST one
  function automatic logic [11:0] ro_index(input logic [15:0] a, input region_t r);
    case (r)
      REG_ALARM: ro_index = 12'(a - ALARM_BASE + 16'(ALARM_IDX));
      REG_THIST: ro_index = 12'(a - THIST_BASE + 16'(THIST_IDX));
      REG_AHIST: ro_index = 12'(a - AHIST_BASE + 16'(AHIST_IDX));
      REG_LOG: ro_index = 12'(a - LOG_BASE + 16'(LOG_IDX));
      default: ro_index = 12'h000;
    endcase
  endfunction

  // Pin synchronisers: a change counts once stages two and three agree
  logic [SYNC_N-1:0] pins_raw;
  logic [SYNC_N-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
  assign pins_raw = {timebase_in, start_status_button_n_in, vcc_present_in, comm_mode_select_in};

  always_comb begin
    for (int i = 0; i < SYNC_N; i++) begin
      pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
    end
  end

  // Mode resets to async so a floating select pin reads as low
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= 4'h6;
      s2_q <= 4'h6;
      s3_q <= 4'h6;
      pin_q <= 4'h6;
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  logic mode_sync, vcc_ok, button_n, tb_level;
  assign mode_sync = pin_q[0];
  assign vcc_ok = pin_q[1];
  assign button_n = pin_q[2];
  assign tb_level = pin_q[3];

  // Host access gated by main supply
  logic wr_ok, rd_ok;
  region_t wr_reg, rd_reg;
  assign wr_reg = decode(bus_in.addr);
  assign rd_reg = wr_reg;
  assign wr_ok = bus_in.wr && vcc_ok;
  assign rd_ok = bus_in.rd && vcc_ok;

  // Memories
  logic [7:0] ctrl_mem [0:63];
  logic [7:0] user_mem [0:31];
  logic [7:0] ro_mem [0:RO_BYTES-1];
  logic ctrl_we, user_we;
  assign ctrl_we = wr_ok && (wr_reg == REG_CTRL) && bus_in.addr[5:0] != STATUS1_OFS;
  assign user_we = wr_ok && (wr_reg == REG_USER);

  always_ff @(posedge clock_in) begin
    if (ctrl_we) begin
      ctrl_mem[bus_in.addr[5:0]] <= bus_in.wdata;
    end
    if (user_we) begin
      user_mem[bus_in.addr[4:0]] <= bus_in.wdata;
    end
    if (store_wr_in.en && 32'(store_wr_in.idx) < RO_BYTES) begin
      ro_mem[store_wr_in.idx] <= store_wr_in.data;
    end
  end

  // Control copies that steer logic, kept in flops with a reset value
  logic [7:0] ctrl1_q, ctrl1_d, rate_q, rate_d, dly_lo_q, dly_lo_d, dly_hi_q, dly_hi_d;
  logic [7:0] status_q, status_d;
  logic mission_q, mission_d;
  logic start_pulse;

  always_comb begin
    ctrl1_d = ctrl1_q;
    rate_d = rate_q;
    dly_lo_d = dly_lo_q;
    dly_hi_d = dly_hi_q;
    status_d = status_q;
    mission_d = mission_q;
    if (ctrl_we) begin
      case (bus_in.addr[5:0])
        CTRL1_OFS: ctrl1_d = bus_in.wdata;
        SAMPLE_RATE_OFS: rate_d = bus_in.wdata;
        DELAY_LO_OFS: dly_lo_d = bus_in.wdata;
        DELAY_HI_OFS: dly_hi_d = bus_in.wdata;
        default: ;
      endcase
    end
    // Writing one clears a flag; a same-cycle event keeps it set
    if (wr_ok && wr_reg == REG_CTRL && bus_in.addr[5:0] == STATUS1_OFS) begin
      status_d[2:0] = status_q[2:0] & ~(bus_in.wdata[2:0] & FLAG_MASK);
    end
    status_d[2:0] = status_d[2:0] | flag_set_in;
    if (start_pulse) begin
      mission_d = 1'b1;
    end
    status_d[MIP_BIT] = mission_d;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl1_q <= CTRL_RESET;
      rate_q <= CTRL_RESET;
      dly_lo_q <= CTRL_RESET;
      dly_hi_q <= CTRL_RESET;
      status_q <= STATUS_RESET;
      mission_q <= 1'b0;
    end else begin
      ctrl1_q <= ctrl1_d;
      rate_q <= rate_d;
      dly_lo_q <= dly_lo_d;
      dly_hi_q <= dly_hi_d;
      status_q <= status_d;
      mission_q <= mission_d;
    end
  end

  // Read path; the whole byte store is looked at in one cycle
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    if (rd_ok) begin
      case (rd_reg)
        REG_CTRL: begin
          case (bus_in.addr[5:0])
            CTRL1_OFS: rdata_d = ctrl1_q;
            SAMPLE_RATE_OFS: rdata_d = rate_q;
            DELAY_LO_OFS: rdata_d = dly_lo_q;
            DELAY_HI_OFS: rdata_d = dly_hi_q;
            STATUS1_OFS: rdata_d = status_q;
            default: rdata_d = ctrl_mem[bus_in.addr[5:0]];
          endcase
        end
        REG_USER: rdata_d = user_mem[bus_in.addr[4:0]];
        REG_SERIAL: rdata_d = SERIAL_NUMBER[8 * bus_in.addr[2:0] +: 8];
        REG_RESERVED: rdata_d = 8'h00;
        default: rdata_d = ro_mem[ro_index(bus_in.addr, rd_reg)];
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign rdata_out = rdata_q;

  // Button qualification on timebase rising edges
  typedef enum {BTN_IDLE, BTN_COUNT, BTN_HELD} btn_state_t;
  btn_state_t btn_q, btn_d;
  logic [CNT_W-1:0] low_cnt_q, low_cnt_d;
  logic tb_prev_q, tb_rise, btn_prev_q, press;
  assign tb_rise = tb_level && !tb_prev_q;
  assign press = !button_n && btn_prev_q;

  always_comb begin
    btn_d = btn_q;
    low_cnt_d = low_cnt_q;
    start_pulse = 1'b0;
    case (btn_q)
      BTN_IDLE: begin
        low_cnt_d = '0;
        if (!button_n && !mission_q && ctrl1_q[SE_BIT]) begin
          btn_d = BTN_COUNT;
        end
      end
      BTN_COUNT: begin
        if (button_n) begin
          btn_d = BTN_IDLE;
        end else if (tb_rise) begin
          if (low_cnt_q == LOW_LAST) begin
            start_pulse = 1'b1;
            btn_d = BTN_HELD;
          end else begin
            low_cnt_d = low_cnt_q + 1'b1;
          end
        end
      end
      BTN_HELD: begin
        if (button_n) begin
          btn_d = BTN_IDLE;
        end
      end
      default: btn_d = BTN_IDLE;
    endcase
  end

  // Status report held while the button stays down
  logic rep_in_q, rep_in_d, rep_out_q, rep_out_d;
  always_comb begin
    rep_in_d = rep_in_q;
    rep_out_d = rep_out_q;
    if (button_n) begin
      rep_in_d = 1'b0;
      rep_out_d = 1'b0;
    end else if (press && mission_q) begin
      rep_in_d = (status_q[2:0] == 3'h0);
      rep_out_d = (status_q[2:0] != 3'h0);
    end
  end

  logic tx_q, tx_oe_q, int_q, start_q;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      btn_q <= BTN_IDLE;
      low_cnt_q <= '0;
      tb_prev_q <= 1'b0;
      btn_prev_q <= 1'b1;
      rep_in_q <= 1'b0;
      rep_out_q <= 1'b0;
      tx_q <= 1'b1;
      tx_oe_q <= 1'b0;
      int_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      btn_q <= btn_d;
      low_cnt_q <= low_cnt_d;
      tb_prev_q <= tb_level;
      btn_prev_q <= button_n;
      rep_in_q <= rep_in_d;
      rep_out_q <= rep_out_d;
      tx_q <= tx_data_in;
      tx_oe_q <= vcc_ok && !mode_sync;
      int_q <= |(status_q[2:0] & ctrl1_q[2:0]);
      start_q <= start_pulse;
    end
  end

  // Only one port is live at a time; neither on battery alone except in and just after reset, as the supply bit resets to present
  assign sync_port_en_out = vcc_ok && mode_sync;
  assign async_port_en_out = vcc_ok && !mode_sync;
  assign tx_out = tx_q;
  assign tx_oe_out = tx_oe_q;
  assign int_n_out = 1'b0;
  assign int_n_oe_out = int_q;
  assign in_limits_indicator_out = 1'b0;
  assign in_limits_indicator_oe_out = rep_in_q;
  assign out_of_limits_indicator_out = 1'b0;
  assign out_of_limits_indicator_oe_out = rep_out_q;
  assign mission_start_out = start_q;
  assign mission_cfg_out = '{sample_rate: rate_q, start_delay: {dly_hi_q, dly_lo_q}};
endmodule

// File: tb/timebase_model.sv
// Free-running timebase crystal model for the recorder bench.
// Assumes the block samples it on its own clock.
`timescale 1ns/100ps
module timebase_model (
  output logic timebase_out
);
  // Crystal runs free; odd start offset keeps phase unrelated to the clock
  // Period cut to 60 ns so the half-second count fits the run budget;
  // each level still lasts three clocks, enough for the pin filter
  initial begin
    timebase_out = 1'b0;
    #3.3;
    forever #30 timebase_out = ~timebase_out;
  end
endmodule

// File: tb/recorder_pins_chk.sv
// Port checker for the recorder pin and memory-map block.
// Assumes pin filters settle within 6 clocks.
`timescale 1ns/100ps
module recorder_pins_chk
  import recorder_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire recorder_pkg::bus_req_t bus_in,
  input wire logic [7:0] rdata_out,
  input wire logic comm_mode_select_in,
  input wire logic vcc_present_in,
  input wire logic start_status_button_n_in,
  input wire logic timebase_in,
  input wire logic tx_oe_out,
  input wire logic sync_port_en_out,
  input wire logic async_port_en_out,
  input wire logic in_limits_indicator_oe_out,
  input wire logic out_of_limits_indicator_oe_out,
  input wire logic mission_start_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // Timebase rises seen while the button pin stays low, saturating
  logic [15:0] low_rises_q;
  logic tb_seen_q;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      low_rises_q <= 16'h0000;
      tb_seen_q <= 1'b0;
    end else begin
      tb_seen_q <= timebase_in;
      if (start_status_button_n_in) begin
        low_rises_q <= 16'h0000;
      end else if (timebase_in && !tb_seen_q && low_rises_q != 16'hffff) begin
        low_rises_q <= low_rises_q + 16'h0001;
      end
    end
  end
  property p_sel;
    (comm_mode_select_in && vcc_present_in) [*6] |-> sync_port_en_out
      && !async_port_en_out && !tx_oe_out;
  endproperty
  a_sel: assert property (p_sel) else $error("sync select not honoured");
  property p_async;
    (!comm_mode_select_in && vcc_present_in) [*6] |-> async_port_en_out
      && !sync_port_en_out;
  endproperty
  a_async: assert property (p_async) else $error("async select not honoured");
  property p_txz;
    !vcc_present_in [*6] |-> !tx_oe_out && !sync_port_en_out && !async_port_en_out;
  endproperty
  a_txz: assert property (p_txz) else $error("tx driven without supply");
  property p_novcc;
    !vcc_present_in [*6] ##0 bus_in.rd |=> rdata_out == 8'h00;
  endproperty
  a_novcc: assert property (p_novcc) else $error("read served without supply");
  property p_rsv;
    bus_in.rd && bus_in.addr inside {[16'h0060:16'h0217]} |=> rdata_out == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved page not zero");
  property p_pulse;
    mission_start_out |=> !mission_start_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_start;
    mission_start_out |-> !$past(start_status_button_n_in, 4)
      && $past(low_rises_q, 4) >= 16'(BUTTON_LOW_SAMPLES - 1);
  endproperty
  a_start: assert property (p_start) else $error("start without held button");
  property p_ind;
    start_status_button_n_in [*6] |-> !in_limits_indicator_oe_out
      && !out_of_limits_indicator_oe_out;
  endproperty
  a_ind: assert property (p_ind) else $error("indicator without press");
endmodule
bind recorder_pins recorder_pins_chk u_recorder_pins_chk (.*);

// File: tb/tb_top.sv
// Self-checking bench for the recorder pin and memory-map block.
// Assumes the timebase model and the bound checker beside it.
`timescale 1ns/100ps
module tb_top;
  import recorder_pkg::*;
  localparam logic [63:0] SN = 64'h0123456789abcdef; // Arbitrary value
  logic clock_in, nrst_in, comm_mode_select_in, vcc_present_in, tx_data_in, tx_out;
  logic start_status_button_n_in, timebase_in, tx_oe_out, int_n_out, int_n_oe_out;
  logic sync_port_en_out, async_port_en_out, mission_start_out, rd_prev;
  logic in_limits_indicator_out, in_limits_indicator_oe_out;
  logic out_of_limits_indicator_out, out_of_limits_indicator_oe_out;
  logic [2:0] flag_set_in;
  logic [7:0] rdata_out, d;
  bus_req_t bus_in;
  store_wr_t store_wr_in;
  mission_cfg_t mission_cfg_out;
  logic [7:0] q[$];
  int fails, compares, starts, i;
  logic [15:0] ra[8] = '{16'h0220, 16'h027f, 16'h0800, 16'h087d, 16'h0880, 16'h08ff,
    16'h1000, 16'h17ff};
  logic [11:0] ix[8] = '{12'h000, 12'h05f, 12'h060, 12'h0dd, 12'h0e0, 12'h15f,
    12'h160, 12'h95f};
  logic [15:0] rz[8] = '{16'h0060, 16'h0217, 16'h0280, 16'h07ff, 16'h087e, 16'h0900,
    16'h0fff, 16'h1800};
  recorder_pins #(.SERIAL_NUMBER(SN)) u_recorder_pins (.clock_in, .nrst_in, .bus_in,
    .rdata_out, .store_wr_in, .flag_set_in, .comm_mode_select_in, .vcc_present_in,
    .start_status_button_n_in, .timebase_in, .tx_data_in, .tx_out, .tx_oe_out,
    .sync_port_en_out, .async_port_en_out, .int_n_out, .int_n_oe_out,
    .in_limits_indicator_out, .in_limits_indicator_oe_out, .out_of_limits_indicator_out,
    .out_of_limits_indicator_oe_out, .mission_start_out, .mission_cfg_out);
  timebase_model u_timebase_model (.timebase_out(timebase_in));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock_in);
    bus_in <= '{a, v, 1'b1, 1'b0};
    @(posedge clock_in);
    bus_in <= '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock_in);
    bus_in <= '{a, 8'h00, 1'b0, 1'b1};
    q.push_back(e);
    @(posedge clock_in);
    bus_in <= '0;
  endtask
  task automatic st(input logic [11:0] x, input logic [7:0] v);
    @(posedge clock_in);
    store_wr_in <= '{1'b1, x, v};
    @(posedge clock_in);
    store_wr_in <= '0;
  endtask
  task automatic flag(input logic [2:0] f);
    @(posedge clock_in);
    flag_set_in <= f;
    @(posedge clock_in);
    flag_set_in <= 3'h0;
  endtask
  task automatic btn(input logic v);
    @(posedge clock_in) start_status_button_n_in <= v;
    cyc(6);
  endtask
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Read data stands one cycle only, so it is sampled mid-cycle
  always @(negedge clock_in) begin
    if (rd_prev)
      chk("rdata", rdata_out, q.pop_front());
    rd_prev = bus_in.rd;
    if (mission_start_out === 1'b1)
      starts++;
  end
  initial begin
    nrst_in = 1'b0;
    bus_in = '0;
    store_wr_in = '0;
    flag_set_in = 3'h0;
    comm_mode_select_in = 1'b0;
    vcc_present_in = 1'b1;
    start_status_button_n_in = 1'b1;
    tx_data_in = 1'b1;
    rd_prev = 1'b0;
    void'($urandom(68));
    cyc(4);
    @(posedge clock_in) nrst_in <= 1'b1;
    cyc(6);
    chk("async_en", async_port_en_out, 1'b1);
    chk("tx_oe", tx_oe_out, 1'b1);
    @(posedge clock_in) tx_data_in <= 1'b0;
    cyc(2);
    chk("tx", tx_out, 1'b0);
    @(posedge clock_in) comm_mode_select_in <= 1'b1;
    cyc(6);
    chk("sync_en", sync_port_en_out, 1'b1);
    chk("tx_oe", tx_oe_out, 1'b0);
    @(posedge clock_in) comm_mode_select_in <= 1'b0;
    $display("end pins");
    d = 8'($urandom());
    wr(16'h0041, d);
    @(posedge clock_in) vcc_present_in <= 1'b0;
    cyc(6);
    chk("tx_oe", tx_oe_out, 1'b0);
    wr(16'h0041, ~d);
    rd(16'h0041, 8'h00);
    @(posedge clock_in) vcc_present_in <= 1'b1;
    cyc(6);
    rd(16'h0041, d);
    $display("end supply");
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom());
      st(ix[i], d);
      wr(ra[i], ~d);
      rd(ra[i], d);
      wr(rz[i], d);
      rd(rz[i], 8'h00);
      rd(16'h0218 + 16'(i), SN[8*i +: 8]);
    end
    wr(16'h0218, 8'h00);
    rd(16'h0218, SN[7:0]);
    wr(16'h005f, d);
    wr(16'h003f, ~d);
    rd(16'h005f, d);
    rd(16'h003f, ~d);
    $display("end map");
    wr(16'h000d, 8'h2c);
    wr(16'h0012, 8'h34);
    wr(16'h0013, 8'h12);
    cyc(2);
    chk("cfg", mission_cfg_out, 24'h2c1234);
    wr(16'h000e, 8'h01);
    flag(3'h1);
    cyc(2);
    chk("int", int_n_oe_out, 1'b1);
    rd(16'h0014, 8'h01);
    wr(16'h0014, 8'h01);
    cyc(2);
    chk("int", int_n_oe_out, 1'b0);
    wr(16'h000e, 8'h10);
    flag(3'h1);
    cyc(2);
    chk("int", int_n_oe_out, 1'b0);
    wr(16'h0014, 8'h07);
    $display("end interrupt");
    btn(1'b0);
    cyc(1000);
    btn(1'b1);
    chk("starts", starts, 0);
    @(posedge clock_in) start_status_button_n_in <= 1'b0;
    for (i = 0; i < 99000 && starts == 0; i++)
      @(posedge clock_in);
    // A start that never comes counts once here; the rest still ends in the report
    if (starts == 0)
      fails++;
    cyc(2);
    chk("starts", starts, 1);
    rd(16'h0014, 8'h20);
    btn(1'b1);
    flag(3'h2);
    btn(1'b0);
    chk("out_oe", out_of_limits_indicator_oe_out, 1'b1);
    chk("in_oe", in_limits_indicator_oe_out, 1'b0);
    btn(1'b1);
    chk("out_oe", out_of_limits_indicator_oe_out, 1'b0);
    wr(16'h0014, 8'h07);
    btn(1'b0);
    chk("in_oe", in_limits_indicator_oe_out, 1'b1);
    chk("od_levels", {21'h0, int_n_out, in_limits_indicator_out, out_of_limits_indicator_out}, 24'h000000);
    btn(1'b1);
    $display("end button");
    report_and_stop();
  end
endmodule
